// ### rtl/dsc_pkg.sv
// Package: register map, field layout and reset values of the driver status/config bank
package dsc_pkg;

  // ****************************************
  // Register offsets (register port addresses)
  // ****************************************
  localparam logic [6:0] ADDR_INPUT_PIN_STATUS = 7'h04;
  localparam logic [6:0] ADDR_DRIVER_CONFIGURATION = 7'h0A;
  localparam logic [6:0] ADDR_GLOBAL_CURRENT_SCALE = 7'h0B;

  // ****************************************
  // input_pin_status field positions
  // ****************************************
  localparam int VERSION_LSB = 24;
  localparam int SILICON_REVISION_LSB = 16;
  localparam int ADC_FAULT_BIT = 15;
  localparam int CLOCK_SOURCE_FLAG_BIT = 14;
  localparam int REF_RESISTOR_DETECT_BIT = 13;
  localparam int OUTPUT_POLARITY_BIT = 12;
  localparam int COMPARATOR_LSB = 8;
  localparam int UART_SELECT_BIT = 6;
  localparam int PIN_STATE_LSB = 0;

  // ****************************************
  // driver_configuration and global_current_scale fields
  // ****************************************
  localparam int SLOPE_SETTING_LSB = 4;
  localparam int CURRENT_RANGE_LSB = 0;
  localparam int GLOBAL_SCALE_LSB = 0;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic OUTPUT_POLARITY_RESET = 1'b1;
  localparam logic [1:0] SLOPE_SETTING_RESET = 2'h0;
  localparam logic [1:0] CURRENT_RANGE_RESET = 2'h0;
  localparam logic [7:0] GLOBAL_SCALE_RESET = 8'h00;

  // Zero scaler means full scale, i.e. 256/256
  localparam logic [8:0] FULL_SCALE_FACTOR = 9'h100;
  localparam int SCALE_SHIFT = 8;

  // Live input pins, in the order they sit in bits 5:0
  typedef struct packed {
    logic encoderIndexState;
    logic driverDisableState;
    logic encoderChanAState;
    logic encoderChanBState;
    logic dir;
    logic step;
  } dsc_pins_t;

  // Comparator states, bits 11:8
  typedef struct packed {
    logic loadComparatorB;
    logic loadComparatorA;
    logic chopperComparatorB;
    logic chopperComparatorA;
  } dsc_comp_t;

  // Analog / strap status flags
  typedef struct packed {
    logic adcFault;
    logic clockSourceFlag;
    logic refResistorDetect;
    logic uartSelect;
  } dsc_flags_t;

endpackage

// ### rtl/dsc_regs.sv
// Driver status and configuration register bank with global current scaling
//
// Behaviour
// [RL1] Status top byte version, revision at 18:16
// [RL2] ADC fault flag; software avoids ADC features
// [RL3] Clock flag: 0 internal, 1 external oscillator
// [RL4] Flag reports external reference resistor present
// [RL5] Writable next-address output polarity, resets to 1
// [RL6] Four read-only test comparator state bits
// [RL7] Interface select bit reads 1 for UART
// [RL8] Live pin states readable without side effect
// [RL9] Global_current_scale multiplies current, zero full scale
// [RL10] Slope and current range settings, reset zero
`timescale 1ns/1ps
`default_nettype none
module dsc_regs #(
  parameter logic [7:0] VERSION_CODE = 8'h5A, // Arbitrary value
  parameter logic [2:0] SILICON_REVISION = 3'h1 // Arbitrary value
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port behind the serial interface framing
  input wire logic [6:0] regAddr,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [31:0] regWrData,
  output logic [31:0] regRdData,
  output logic regRdValid,
  // Asynchronous status inputs
  input wire dsc_pkg::dsc_pins_t pinsIn,
  input wire dsc_pkg::dsc_comp_t compIn,
  input wire dsc_pkg::dsc_flags_t flagsIn,
  // Current scaling path, same clock
  input wire logic [7:0] motorCurrent,
  output logic [7:0] scaledCurrent,
  // Configuration outputs
  output logic nextAddressOutput,
  output logic [1:0] slopeSetting,
  output logic [1:0] currentRange,
  output logic [7:0] globalCurrentScale
);

  // ****************************************
  // Reset release and input synchronisation
  // ****************************************
  logic rstMeta_r;
  logic rstSync_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_r <= 1'b0;
      rstSync_r <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSync_r <= rstMeta_r;
    end
  end

  dsc_pkg::dsc_pins_t pinsSync;
  dsc_pkg::dsc_comp_t compSync;
  dsc_pkg::dsc_flags_t flagsSync;

  dsc_sync #(.WIDTH(14)) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rstSync_r),
    .asyncIn({pinsIn, compIn, flagsIn}),
    .syncOut({pinsSync, compSync, flagsSync})
  );

  // ****************************************
  // Address decode
  // ****************************************
  wire logic hitStatus = (regAddr == dsc_pkg::ADDR_INPUT_PIN_STATUS);
  wire logic hitDrvConf = (regAddr == dsc_pkg::ADDR_DRIVER_CONFIGURATION);
  wire logic hitScale = (regAddr == dsc_pkg::ADDR_GLOBAL_CURRENT_SCALE);
  wire logic wrStatus = regWrEn && hitStatus;
  wire logic wrDrvConf = regWrEn && hitDrvConf;
  wire logic wrScale = regWrEn && hitScale;

  // ****************************************
  // Writable fields
  // ****************************************
  logic outputPolarity_r;
  logic [1:0] slope_r;
  logic [1:0] range_r;
  logic [7:0] scale_r;

  always_ff @(posedge clk_sys or negedge rstSync_r) begin
    if (!rstSync_r) begin
      outputPolarity_r <= dsc_pkg::OUTPUT_POLARITY_RESET;
      slope_r <= dsc_pkg::SLOPE_SETTING_RESET;
      range_r <= dsc_pkg::CURRENT_RANGE_RESET;
      scale_r <= dsc_pkg::GLOBAL_SCALE_RESET;
    end else begin
      if (wrStatus) begin
        outputPolarity_r <= regWrData[dsc_pkg::OUTPUT_POLARITY_BIT]; // RL5
      end
      if (wrDrvConf) begin
        slope_r <= regWrData[dsc_pkg::SLOPE_SETTING_LSB +: 2]; // RL10
        range_r <= regWrData[dsc_pkg::CURRENT_RANGE_LSB +: 2]; // RL10
      end
      if (wrScale) begin
        scale_r <= regWrData[dsc_pkg::GLOBAL_SCALE_LSB +: 8]; // RL9
      end
    end
  end

  // ****************************************
  // Read data assembly
  // ****************************************
  // Reserved bits 23:19 and 7 read as zero
  logic [31:0] statusWord;
  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[dsc_pkg::VERSION_LSB +: 8] = VERSION_CODE; // RL1
    statusWord[dsc_pkg::SILICON_REVISION_LSB +: 3] = SILICON_REVISION; // RL1
    statusWord[dsc_pkg::ADC_FAULT_BIT] = flagsSync.adcFault; // RL2
    statusWord[dsc_pkg::CLOCK_SOURCE_FLAG_BIT] = flagsSync.clockSourceFlag; // RL3
    statusWord[dsc_pkg::REF_RESISTOR_DETECT_BIT] = flagsSync.refResistorDetect; // RL4
    statusWord[dsc_pkg::OUTPUT_POLARITY_BIT] = outputPolarity_r; // RL5
    statusWord[dsc_pkg::COMPARATOR_LSB +: 4] = compSync; // RL6
    statusWord[dsc_pkg::UART_SELECT_BIT] = flagsSync.uartSelect; // RL7
    statusWord[dsc_pkg::PIN_STATE_LSB +: 6] = pinsSync; // RL8
  end

  logic [31:0] drvConfWord;
  logic [31:0] scaleWord;
  always_comb begin
    drvConfWord = 32'h0000_0000;
    drvConfWord[dsc_pkg::SLOPE_SETTING_LSB +: 2] = slope_r;
    drvConfWord[dsc_pkg::CURRENT_RANGE_LSB +: 2] = range_r;
    scaleWord = 32'h0000_0000;
    scaleWord[dsc_pkg::GLOBAL_SCALE_LSB +: 8] = scale_r;
  end

  // Unmapped addresses return zero; reads change no state
  wire logic [31:0] rdMux = hitStatus ? statusWord :
                            hitDrvConf ? drvConfWord :
                            hitScale ? scaleWord : 32'h0000_0000; // RL8

  always_ff @(posedge clk_sys or negedge rstSync_r) begin
    if (!rstSync_r) begin
      regRdData <= 32'h0000_0000;
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regRdEn;
      if (regRdEn) begin
        regRdData <= rdMux;
      end
    end
  end

  // ****************************************
  // Current scaling and configuration outputs
  // ****************************************
  // Values 1..31 are not blocked: software must avoid them
  wire logic [8:0] scaleFactor = (scale_r == 8'h00) ? dsc_pkg::FULL_SCALE_FACTOR : {1'b0, scale_r}; // RL9
  wire logic [16:0] scaleProduct = 17'(motorCurrent * scaleFactor);
  wire logic [7:0] scaledNxt = scaleProduct[dsc_pkg::SCALE_SHIFT +: 8];
  // Pin only carries the polarity level in UART mode; SPI owns it otherwise
  wire logic nextAddrNxt = flagsSync.uartSelect & outputPolarity_r; // RL5

  always_ff @(posedge clk_sys or negedge rstSync_r) begin
    if (!rstSync_r) begin
      scaledCurrent <= 8'h00;
      nextAddressOutput <= 1'b0;
      slopeSetting <= dsc_pkg::SLOPE_SETTING_RESET;
      currentRange <= dsc_pkg::CURRENT_RANGE_RESET;
      globalCurrentScale <= dsc_pkg::GLOBAL_SCALE_RESET;
    end else begin
      scaledCurrent <= scaledNxt; // RL9
      nextAddressOutput <= nextAddrNxt;
      slopeSetting <= slope_r; // RL10
      currentRange <= range_r; // RL10
      globalCurrentScale <= scale_r;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstSync_r);

  version_field_a: assert property ( // RL1
    regRdEn && hitStatus |=> regRdValid && regRdData[31:24] == VERSION_CODE
      && regRdData[18:16] == SILICON_REVISION && regRdData[23:19] == 5'h00)
    else $error("version or revision field wrong");

  adc_flag_a: assert property ( // RL2
    regRdEn && hitStatus |=> regRdData[15] == $past(flagsSync.adcFault))
    else $error("ADC fault flag not reported");

  // The synchroniser is still held at the edge where the internal reset lifts
  clock_flag_a: assert property ( // RL3
    rstSync_r && $rose(flagsIn.clockSourceFlag) ##1 $stable(flagsIn.clockSourceFlag) |=> flagsSync.clockSourceFlag)
    else $error("clock source flag not synchronised in time");

  ref_detect_a: assert property ( // RL4
    regRdEn && hitStatus |=> regRdData[13] == $past(flagsSync.refResistorDetect))
    else $error("reference resistor flag wrong");

  polarity_write_a: assert property ( // RL5
    wrStatus |=> outputPolarity_r == $past(regWrData[12]) ##1
      nextAddressOutput == ($past(outputPolarity_r) & $past(flagsSync.uartSelect)))
    else $error("output polarity write or pin level wrong");

  comparator_bits_a: assert property ( // RL6
    regRdEn && hitStatus |=> regRdData[11:8] == $past(compSync))
    else $error("comparator bits wrong");

  uart_select_a: assert property ( // RL7
    regRdEn && hitStatus |=> regRdData[6] == $past(flagsSync.uartSelect) && !regRdData[7])
    else $error("interface select bit wrong");

  pin_state_a: assert property ( // RL8
    regRdEn && hitStatus && !regWrEn |=> regRdData[5:0] == $past(pinsSync)
      && outputPolarity_r == $past(outputPolarity_r))
    else $error("pin states wrong or read had side effect");

  scale_math_a: assert property ( // RL9
    rstSync_r && scale_r == 8'h00 ##1 scale_r == 8'h00 |-> scaledCurrent == $past(motorCurrent))
    else $error("zero scaler is not full scale");

  // A scaler of 32 is one eighth of full scale
  scale_eighth_a: assert property ( // RL9
    rstSync_r && scale_r == 8'h20 |=> scaledCurrent == ($past(motorCurrent) >> 3))
    else $error("scaler of 32 does not give one eighth");

  driver_configuration_a: assert property ( // RL10
    wrDrvConf ##1 !wrDrvConf |=> slopeSetting == $past(regWrData[5:4], 2) && currentRange == $past(regWrData[1:0], 2))
    else $error("driver configuration not applied");

endmodule // dsc_regs
`default_nettype wire

// ### rtl/dsc_sync.sv
// Two-flop synchroniser for a group of asynchronous level inputs
`timescale 1ns/1ps
`default_nettype none
module dsc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stage1_r <= '0;
      syncOut <= '0;
    end else begin
      stage1_r <= asyncIn;
      syncOut <= stage1_r;
    end
  end
endmodule // dsc_sync
`default_nettype wire

// ### verif/dsc_regs_test.sv
// Self-checking testbench for the driver status and configuration register bank
`timescale 1ns/1ps
`default_nettype none
module dsc_regs_test;
  localparam logic [7:0] VER = 8'h3C; // Arbitrary value
  localparam logic [2:0] REV = 3'h5; // Arbitrary value
  logic clk_sys, rst_n, regWrEn, regRdEn, regRdValid, nextAddressOutput, pol;
  logic [6:0] regAddr;
  logic [31:0] regWrData, regRdData, lfsr, d;
  logic [7:0] motorCurrent, scaledCurrent, globalCurrentScale, s;
  logic [1:0] slopeSetting, currentRange;
  logic [13:0] v;
  dsc_pkg::dsc_pins_t pinsIn;
  dsc_pkg::dsc_comp_t compIn;
  dsc_pkg::dsc_flags_t flagsIn;
  int error_cnt, n_checks;

  dsc_regs #(.VERSION_CODE(VER), .SILICON_REVISION(REV)) dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid), .pinsIn(pinsIn),
    .compIn(compIn), .flagsIn(flagsIn), .motorCurrent(motorCurrent), .scaledCurrent(scaledCurrent),
    .nextAddressOutput(nextAddressOutput), .slopeSetting(slopeSetting), .currentRange(currentRange),
    .globalCurrentScale(globalCurrentScale)
  );

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] next_rand(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic logic [31:0] exp_status(input logic p);
    return {VER, 5'h00, REV, flagsIn.adcFault, flagsIn.clockSourceFlag, flagsIn.refResistorDetect, p,
      compIn, 1'b0, flagsIn.uartSelect, pinsIn};
  endfunction

  // Zero scale stands for 256/256; the product is truncated
  function automatic logic [7:0] exp_scale(input logic [7:0] m, input logic [7:0] sc);
    logic [16:0] p;
    p = {9'h000, m} * ((sc == 8'h00) ? 17'h00100 : {9'h000, sc});
    return p[15:8];
  endfunction

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic wr(input logic [6:0] a, input logic [31:0] dat);
    regAddr = a;
    regWrData = dat;
    regWrEn = 1'b1;
    tick(1);
    regWrEn = 1'b0;
    // Let an edge pass so a following call never re-raises the strobe in the same step
    tick(1);
  endtask

  task automatic rd(input logic [6:0] a, input logic [31:0] exp);
    regAddr = a;
    regRdEn = 1'b1;
    tick(1);
    regRdEn = 1'b0;
    cmp({31'h0, regRdValid}, 32'h1);
    cmp(regRdData, exp);
    tick(1);
  endtask

  task automatic stop_test;
    if (error_cnt == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Watchdog so a stuck run still reaches the verdict
  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    stop_test();
  end

  initial begin
    lfsr = 32'he615;
    error_cnt = 0;
    n_checks = 0;
    rst_n = 1'b0;
    regAddr = 7'h00;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regWrData = 32'h0;
    pinsIn = '0;
    compIn = '0;
    flagsIn = '0;
    motorCurrent = 8'h00;
    pol = 1'b1;
    tick(10);
    rst_n = 1'b1;
    tick(5);
    // ****************************************
    // Reset state
    // ****************************************
    cmp({19'h0, nextAddressOutput, slopeSetting, currentRange, globalCurrentScale}, 32'h0);
    rd(dsc_pkg::ADDR_DRIVER_CONFIGURATION, 32'h0);
    rd(dsc_pkg::ADDR_GLOBAL_CURRENT_SCALE, 32'h0);
    rd(dsc_pkg::ADDR_INPUT_PIN_STATUS, exp_status(1'b1));
    tick(1);
    cmp({31'h0, regRdValid}, 32'h0);
    rd(7'h05, 32'h0);
    // ****************************************
    // Status bits: walking one, then random
    // ****************************************
    for (int i = 0; i < 34; i++) begin
      v = (i < 14) ? (14'h0001 << i) : lfsr[13:0];
      {flagsIn, compIn, pinsIn} = v;
      if (i % 4 == 3) begin
        wr(dsc_pkg::ADDR_INPUT_PIN_STATUS, lfsr);
        pol = lfsr[12];
      end
      lfsr = next_rand(lfsr);
      tick(3);
      rd(dsc_pkg::ADDR_INPUT_PIN_STATUS, exp_status(pol));
      rd(dsc_pkg::ADDR_INPUT_PIN_STATUS, exp_status(pol));
      cmp({31'h0, nextAddressOutput}, {31'h0, flagsIn.uartSelect & pol});
    end
    // ****************************************
    // Configuration, scaler and current scaling
    // ****************************************
    for (int i = 0; i < 16; i++) begin
      d = (i < 4) ? {lfsr[31:6], i[1:0], lfsr[3:2], i[1:0]} : lfsr;
      lfsr = next_rand(lfsr);
      s = (i == 0) ? 8'h00 : (i == 1) ? 8'h20 : (i == 2) ? 8'hFF : lfsr[7:0];
      s = (s[7:5] == 3'h0) ? 8'h00 : s;
      wr(dsc_pkg::ADDR_DRIVER_CONFIGURATION, d);
      wr(dsc_pkg::ADDR_GLOBAL_CURRENT_SCALE, {lfsr[31:8], s});
      tick(1);
      cmp({28'h0, slopeSetting, currentRange}, {28'h0, d[5:4], d[1:0]});
      cmp({24'h0, globalCurrentScale}, {24'h0, s});
      rd(dsc_pkg::ADDR_DRIVER_CONFIGURATION, {26'h0, d[5:4], 2'h0, d[1:0]});
      rd(dsc_pkg::ADDR_GLOBAL_CURRENT_SCALE, {24'h0, s});
      for (int k = 0; k < 3; k++) begin
        motorCurrent = (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : lfsr[15:8];
        tick(1);
        cmp({24'h0, scaledCurrent}, {24'h0, exp_scale(motorCurrent, s)});
      end
    end
    // ****************************************
    // Reset in mid-run
    // ****************************************
    rst_n = 1'b0;
    #1;
    cmp({11'h0, nextAddressOutput, slopeSetting, currentRange, globalCurrentScale, scaledCurrent}, 32'h0);
    tick(10);
    rst_n = 1'b1;
    tick(5);
    rd(dsc_pkg::ADDR_INPUT_PIN_STATUS, exp_status(1'b1));
    rd(dsc_pkg::ADDR_DRIVER_CONFIGURATION, 32'h0);
    stop_test();
  end
endmodule // dsc_regs_test
`default_nettype wire
